// ===== pkg/trig_sel_pkg.sv
package trig_sel_pkg;

    // Register map and bus answers.
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_SRC_SEL  = 8'h00;
    localparam logic [7:0]  OFS_MODE_CFG = 8'h04;
    localparam logic [7:0]  OFS_PRESC    = 8'h08;
    localparam logic [7:0]  OFS_CTRL     = 8'h0C;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Reset values and writable bits.
    localparam logic [7:0]  RST_SRC_SEL  = 8'h00;
    localparam logic [15:0] RST_MODE_CFG = 16'h0000;
    localparam logic [15:0] RST_PRESC    = 16'h0000;
    localparam logic [7:0]  SRC_WR_MASK  = 8'h10;
    localparam logic [15:0] MODE_WR_MASK = 16'hD7CF;

    // Field positions.
    localparam int SRC_SEL_BIT    = 4;
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_LVL_BIT   = 0;
    localparam int STAT_START_BIT = 1;
    localparam int STAT_CAPT_BIT  = 2;
    localparam int STAT_BAD_BIT   = 3;

    // Prescaler shape.
    localparam int N_PRESC     = 4;
    localparam int PRESC_SEL_W = 4;
    localparam int PRESC_CNT_W = 15;

    // Field codes.
    localparam logic [1:0] CLK_SEL_0   = 2'h0;
    localparam logic [1:0] CLK_SEL_2   = 2'h1;
    localparam logic [1:0] CLK_SEL_1   = 2'h2;
    localparam logic [1:0] CLK_SEL_3   = 2'h3;
    localparam logic [2:0] TRIG_SW     = 3'h0;
    localparam logic [2:0] TRIG_EDGE   = 3'h1;
    localparam logic [2:0] TRIG_BOTH   = 3'h2;
    localparam logic [2:0] TRIG_MASTER = 3'h4;
    localparam logic [1:0] EDGE_FALL   = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_LOW    = 2'h2;
    localparam logic [1:0] EDGE_HIGH   = 2'h3;

    typedef enum logic [2:0] {
        IDX_SRC    = 3'h0,
        IDX_MODE   = 3'h1,
        IDX_PRESC  = 3'h2,
        IDX_CTRL   = 3'h3,
        IDX_STATUS = 3'h4,
        IDX_NONE   = 3'h7
    } reg_idx_t;

    // Channel mode configuration word, laid out bit for bit.
    typedef struct packed {
        logic [1:0] op_clk_sel;
        logic       rsv13;
        logic       count_clk_src;
        logic       rsv11;
        logic [2:0] trig_sel;
        logic [1:0] edge_sel;
        logic [1:0] rsv5_4;
        logic [3:0] channel_mode;
    } mode_cfg_t;

    // Timing references and triggers handed to the counter.
    typedef struct packed {
        logic op_tick;
        logic count_tick;
        logic start;
        logic capture;
    } trig_t;

endpackage : trig_sel_pkg

// ===== rtl/input_sync3.sv
module input_sync3 #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Raw inputs and filtered levels.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // A level is accepted only when the second and third stage agree.
    always_comb
    begin
        lvl_d = lvl_q;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_q[i] == s3_q[i])
                lvl_d[i] = s3_q[i];
        end
    end

    // The first stage feeds the second stage only.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end
        else
        begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;

endmodule : input_sync3

// ===== rtl/prescale_div.sv
module prescale_div #(
    parameter int N     = 4,
    parameter int SEL_W = 4,
    parameter int CNT_W = 15
) (
    // Clock and reset.
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Per-clock power-of-two select and enable pulses.
    input  wire logic [N*SEL_W-1:0] sel,
    output logic      [N-1:0]       tick
);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [N-1:0]     tick_q, tick_d;

    // One free counter serves every rate, so all enables stay aligned.
    always_comb
    begin
        cnt_d = CNT_W'(cnt_q + 1'b1);
    end

    // A rate of 2^s pulses when the low s counter bits are all ones, s being clock k's select field.
    for (genvar k = 0; k < N; k++)
    begin : g_tick
        always_comb
        begin
            tick_d[k] = &(cnt_q | ({CNT_W{1'b1}} << sel[k*SEL_W +: SEL_W]));
        end
    end

    // Counter and enable registers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            tick_q <= '0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : prescale_div

// ===== rtl/timer_channel_trigger_select.sv
// Notes on behaviour
// - Source bit picks pin or event link.
// - Clock field maps codes to prescaled clocks.
// - Operation clock drives the edge detector.
// - Count on operation clock or valid edges.
// - Count clock times counter, output, interrupts.
// - Code 000: software start only.
// - Code 001: one edge starts and captures.
// - Code 010: both edges, start and capture.
// - Code 100: master interrupt triggers slave.
// - Edge codes 00 falling, 01 rising.
// - Code 10: falling starts, rising captures.
// - Code 11: rising starts, falling captures.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module timer_channel_trigger_select (
    // Clock and reset.
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    // AXI4-Lite register port.
    input  wire logic [trig_sel_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [trig_sel_pkg::ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Timer inputs.
    input  wire logic                          channel0_timer_input_pin,
    input  wire logic                          event_link_logic_sig,
    input  wire logic                          master_irq,
    // Timing references and triggers.
    output trig_sel_pkg::trig_t                trig
);

    logic                      aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [trig_sel_pkg::ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0]               w_data_q, w_data_d;
    logic [3:0]                w_strb_q, w_strb_d;
    logic                      awready_q, awready_d, wready_q, wready_d;
    logic                      bvalid_q, bvalid_d, arready_q, arready_d;
    logic                      rvalid_q, rvalid_d;
    logic [1:0]                bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]               rdata_q, rdata_d;
    logic [7:0]                src_q, src_d;
    trig_sel_pkg::mode_cfg_t   mode_q, mode_d;
    logic [15:0]               presc_q, presc_d;
    logic                      sw_start_q, sw_start_d;
    logic [1:0]                sticky_q, sticky_d;
    logic                      sample_q, sample_d;
    trig_sel_pkg::trig_t       trig_q, trig_d;
    logic [15:0]               m_src, m_mode, m_presc;
    logic [1:0]                clr;
    trig_sel_pkg::reg_idx_t    wr_idx, rd_idx;
    logic [1:0]                lvl;
    logic [3:0]                ck_en;
    logic                      op_en, sel_lvl, rise_ev, fall_ev, valid_ev;
    logic                      first_ev, second_ev, bad_cfg;

    // Address decode shared by the read and write paths.
    function automatic trig_sel_pkg::reg_idx_t decode(
        input logic [trig_sel_pkg::ADDR_W-1:0] a);
        unique case (a)
            trig_sel_pkg::OFS_SRC_SEL:  decode = trig_sel_pkg::IDX_SRC;
            trig_sel_pkg::OFS_MODE_CFG: decode = trig_sel_pkg::IDX_MODE;
            trig_sel_pkg::OFS_PRESC:    decode = trig_sel_pkg::IDX_PRESC;
            trig_sel_pkg::OFS_CTRL:     decode = trig_sel_pkg::IDX_CTRL;
            trig_sel_pkg::OFS_STATUS:   decode = trig_sel_pkg::IDX_STATUS;
            default:                    decode = trig_sel_pkg::IDX_NONE;
        endcase
    endfunction : decode

    // Merges the low two byte lanes of a write into an old value.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
        merge16 = old;
        for (int b = 0; b < 2; b++)
        begin
            if (strb[b])
                merge16[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction : merge16

    // Both inputs take the same filter so the source switch is fair.
    input_sync3 #(
        .WIDTH (2)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in ({event_link_logic_sig, channel0_timer_input_pin}),
        .level    (lvl)
    );

    // Prescaled clock enables, one field per clock.
    prescale_div #(
        .N     (trig_sel_pkg::N_PRESC),
        .SEL_W (trig_sel_pkg::PRESC_SEL_W),
        .CNT_W (trig_sel_pkg::PRESC_CNT_W)
    ) u_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (presc_q),
        .tick    (ck_en)
    );

    // Edge detection and trigger selection on the operation clock.
    always_comb
    begin
        unique case (mode_q.op_clk_sel)
            trig_sel_pkg::CLK_SEL_0: op_en = ck_en[0];
            trig_sel_pkg::CLK_SEL_2: op_en = ck_en[2];
            trig_sel_pkg::CLK_SEL_1: op_en = ck_en[1];
            trig_sel_pkg::CLK_SEL_3: op_en = ck_en[3];
        endcase
        sel_lvl = src_q[trig_sel_pkg::SRC_SEL_BIT] ? lvl[1] : lvl[0];
        // Sampling only on op_en keeps the edge detector at that rate; the input filter runs every clk_sys cycle.
        rise_ev  = op_en && sel_lvl && !sample_q;
        fall_ev  = op_en && !sel_lvl && sample_q;
        sample_d = op_en ? sel_lvl : sample_q;
        unique case (mode_q.edge_sel)
            trig_sel_pkg::EDGE_FALL: valid_ev = fall_ev;
            trig_sel_pkg::EDGE_RISE: valid_ev = rise_ev;
            trig_sel_pkg::EDGE_LOW,
            trig_sel_pkg::EDGE_HIGH: valid_ev = rise_ev || fall_ev;
        endcase
        // Odd codes start on rising, even codes on falling.
        first_ev  = mode_q.edge_sel[0] ? rise_ev : fall_ev;
        second_ev = mode_q.edge_sel[0] ? fall_ev : rise_ev;
        trig_d.op_tick    = op_en;
        trig_d.count_tick = mode_q.count_clk_src ? valid_ev : op_en;
        trig_d.start      = sw_start_q;
        trig_d.capture    = 1'b0;
        // Clocks two and three are flagged, never blocked.
        bad_cfg = mode_q.op_clk_sel[0];
        unique case (mode_q.trig_sel)
            trig_sel_pkg::TRIG_SW:
                trig_d.start = sw_start_q;
            trig_sel_pkg::TRIG_EDGE:
            begin
                trig_d.start   = sw_start_q || valid_ev;
                trig_d.capture = valid_ev;
            end
            trig_sel_pkg::TRIG_BOTH:
            begin
                trig_d.start   = sw_start_q || first_ev;
                trig_d.capture = second_ev;
            end
            trig_sel_pkg::TRIG_MASTER:
            begin
                trig_d.start   = sw_start_q || master_irq;
                trig_d.capture = master_irq;
            end
            default:
                bad_cfg = 1'b1;
        endcase
    end

    // Trigger outputs and the sampled input level.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_q   <= '0;
            sample_q <= 1'b0;
        end
        else
        begin
            trig_q   <= trig_d;
            sample_q <= sample_d;
        end
    end

    // Bus slave and register file; a write completes once both halves land.
    always_comb
    begin
        aw_have_d  = aw_have_q;
        aw_addr_d  = aw_addr_q;
        w_have_d   = w_have_q;
        w_data_d   = w_data_q;
        w_strb_d   = w_strb_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        rvalid_d   = rvalid_q;
        rresp_d    = rresp_q;
        rdata_d    = rdata_q;
        src_d      = src_q;
        mode_d     = mode_q;
        presc_d    = presc_q;
        sw_start_d = 1'b0;
        clr        = 2'h0;
        wr_idx     = decode(aw_addr_q);
        rd_idx     = decode(araddr);
        m_src      = merge16({8'h00, src_q}, w_data_q, w_strb_q);
        m_mode     = merge16(mode_q, w_data_q, w_strb_q);
        m_presc    = merge16(presc_q, w_data_q, w_strb_q);
        if (awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (aw_have_q && w_have_q)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = trig_sel_pkg::RESP_OKAY;
            unique case (wr_idx)
                trig_sel_pkg::IDX_SRC:
                    src_d = m_src[7:0] & trig_sel_pkg::SRC_WR_MASK;
                trig_sel_pkg::IDX_MODE:
                    mode_d = m_mode & trig_sel_pkg::MODE_WR_MASK;
                trig_sel_pkg::IDX_PRESC:
                    presc_d = m_presc;
                trig_sel_pkg::IDX_CTRL:
                    sw_start_d = w_strb_q[0]
                                 && w_data_q[trig_sel_pkg::CTRL_START_BIT];
                trig_sel_pkg::IDX_STATUS:
                    clr = w_strb_q[0] ? w_data_q[2:1] : 2'h0;
                default:
                    bresp_d = trig_sel_pkg::RESP_SLVERR;
            endcase
        end
        // Hardware set wins over a clear in the same cycle.
        sticky_d = (sticky_q & ~clr) | {trig_d.capture, trig_d.start};
        if (rvalid_q && rready)
            rvalid_d = 1'b0;
        if (arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = trig_sel_pkg::RESP_OKAY;
            unique case (rd_idx)
                trig_sel_pkg::IDX_SRC:    rdata_d = {24'h000000, src_q};
                trig_sel_pkg::IDX_MODE:   rdata_d = {16'h0000, mode_q};
                trig_sel_pkg::IDX_PRESC:  rdata_d = {16'h0000, presc_q};
                trig_sel_pkg::IDX_CTRL:   rdata_d = 32'h00000000;
                trig_sel_pkg::IDX_STATUS:
                    rdata_d = {28'h0000000, bad_cfg, sticky_q, sample_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = trig_sel_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Bus and register state.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_have_q  <= 1'b0;
            aw_addr_q  <= '0;
            w_have_q   <= 1'b0;
            w_data_q   <= 32'h00000000;
            w_strb_q   <= 4'h0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= 2'h0;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rresp_q    <= 2'h0;
            rdata_q    <= 32'h00000000;
            src_q      <= trig_sel_pkg::RST_SRC_SEL;
            mode_q     <= trig_sel_pkg::RST_MODE_CFG;
            presc_q    <= trig_sel_pkg::RST_PRESC;
            sw_start_q <= 1'b0;
            sticky_q   <= 2'h0;
        end
        else
        begin
            aw_have_q  <= aw_have_d;
            aw_addr_q  <= aw_addr_d;
            w_have_q   <= w_have_d;
            w_data_q   <= w_data_d;
            w_strb_q   <= w_strb_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rresp_q    <= rresp_d;
            rdata_q    <= rdata_d;
            src_q      <= src_d;
            mode_q     <= mode_d;
            presc_q    <= presc_d;
            sw_start_q <= sw_start_d;
            sticky_q   <= sticky_d;
        end
    end

    // Output ports straight from their registers.
    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign trig    = trig_q;

    // Checks on the trigger path.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_sw_only_start:
    assert property (mode_q.trig_sel == trig_sel_pkg::TRIG_SW && !sw_start_q
                     |=> !trig_q.start && !trig_q.capture)
        else $error("Start without software request in code 000.");

    chk_count_opclk:
    assert property (!mode_q.count_clk_src |=> trig_q.count_tick == $past(op_en))
        else $error("Count tick does not follow operation clock.");

    chk_count_edge:
    assert property (mode_q.count_clk_src && mode_q.edge_sel == 2'h1
                     && rise_ev |=> trig_q.count_tick ##1 !trig_q.count_tick)
        else $error("Rising edge did not give one count tick.");

    chk_clk_two_map:
    assert property (mode_q.op_clk_sel == 2'h1 && ck_en[2]
                     |=> trig_q.op_tick)
        else $error("Code 01 did not select prescaled clock two.");

    chk_clk_one_map:
    assert property (mode_q.op_clk_sel == 2'h2
                     |=> trig_q.op_tick == $past(ck_en[1]))
        else $error("Code 10 did not select prescaled clock one.");

    chk_same_edge:
    assert property (mode_q.trig_sel == trig_sel_pkg::TRIG_EDGE
                     && valid_ev |=> trig_q.start && trig_q.capture)
        else $error("Single edge did not both start and capture.");

    chk_low_width:
    assert property (mode_q.trig_sel == 3'h2 && mode_q.edge_sel == 2'h2
                     && fall_ev && !sw_start_q
                     |=> trig_q.start && !trig_q.capture)
        else $error("Falling edge did not start low width run.");

    chk_high_width:
    assert property (mode_q.trig_sel == 3'h2 && mode_q.edge_sel == 2'h3
                     && fall_ev && !sw_start_q
                     |=> trig_q.capture && !trig_q.start)
        else $error("Falling edge did not capture high width.");

    chk_master_trig:
    assert property (mode_q.trig_sel == 3'h4 && master_irq
                     |=> trig_q.start && trig_q.capture)
        else $error("Master interrupt did not trigger the channel.");

    chk_fall_only:
    assert property (mode_q.edge_sel == 2'h0 && mode_q.count_clk_src
                     && rise_ev |=> !trig_q.count_tick)
        else $error("Rising edge counted with falling edge selected.");

    chk_pin_route:
    assert property (!src_q[4] && op_en && lvl[0] != sample_q
                     |=> sample_q == $past(lvl[0]))
        else $error("Pin level not routed with source bit clear.");

endmodule : timer_channel_trigger_select

// ===== verification/far_end_model.sv
module far_end_model (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Selected source and commanded level.
    input  wire logic src_sel,
    input  wire logic lvl,
    // Pin and event link lines.
    output logic      pin,
    output logic      evt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] noise_q;
    // Slow enough to pass the input filter, so a wrong source shows up.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            noise_q <= 3'h0;
        else
            noise_q <= noise_q + 3'h1;
    end
    // Only the selected source carries the commanded level.
    assign pin = src_sel ? noise_q[2] : lvl;
    assign evt = src_sel ? lvl : noise_q[2];
endmodule : far_end_model

// ===== verification/testbench.sv
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic pin, evt, master_irq, src_sel, lvl;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  seen;
    logic [4:0]  n_op, n_cnt;
    int          n_fail, tests_run;
    trig_sel_pkg::trig_t trig;
    logic [15:0] t_mode [7] = '{16'h1041, 16'h1100, 16'h1280, 16'h12C0,
                                16'h1100, 16'h1041, 16'h1080};
    logic [6:0]  t_src = 7'b0110000;
    logic [2:0]  t_rise [7] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h0, 3'h4, 3'h4};
    logic [2:0]  t_fall [7] = '{3'h0, 3'h7, 3'h2, 3'h1, 3'h7, 3'h0, 3'h4};
    logic [2:0]  t_mask [7] = '{3'h7, 3'h7, 3'h3, 3'h3, 3'h7, 3'h7, 3'h7};

    timer_channel_trigger_select u_timer_channel_trigger_select (
        .clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .channel0_timer_input_pin(pin),
        .event_link_logic_sig(evt), .master_irq(master_irq), .trig(trig));
    far_end_model u_far_end_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .src_sel(src_sel), .lvl(lvl), .pin(pin), .evt(evt));

    // Free-running system clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Master side of a write; address and data offered together.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk_sys);
            if (awready === 1'b1 && !aw_done)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        // The response ready stays high so calls never toggle it twice.
        resp = bresp;
    endtask : axi_wr

    // Master side of a read.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_sys);
        v = rdata;
        resp = rresp;
    endtask : axi_rd

    // Collects masked {count, start, capture} pulses over a window.
    task automatic watch(input logic [2:0] m, output logic [2:0] s);
        s = 3'h0;
        repeat (12)
        begin
            @(posedge clk_sys);
            s = s | (m & {trig.count_tick, trig.start, trig.capture});
        end
    endtask : watch

    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // A hang counts as a mismatch.
    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    // Main sequence.
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {master_irq, src_sel, lvl} = 3'h0;
        n_fail = 0;
        tests_run = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        axi_rd(trig_sel_pkg::OFS_SRC_SEL, d, r);
        `CHK("src reset", 32'h0, d)
        axi_rd(trig_sel_pkg::OFS_MODE_CFG, d, r);
        `CHK("mode reset", 32'h0, d)
        axi_wr(trig_sel_pkg::OFS_MODE_CFG, 32'hFFFF, r);
        axi_rd(trig_sel_pkg::OFS_MODE_CFG, d, r);
        `CHK("mode bits", 32'hD7CF, d)
        axi_wr(trig_sel_pkg::OFS_SRC_SEL, 32'hFF, r);
        axi_rd(trig_sel_pkg::OFS_SRC_SEL, d, r);
        `CHK("src bits", 32'h10, d)
        axi_rd(8'h14, d, r);
        `CHK("unmapped", trig_sel_pkg::RESP_SLVERR, r)
        // Each entry: source, mode, then a rising and a falling edge.
        for (int i = 0; i < 7; i++)
        begin
            src_sel <= t_src[i];
            axi_wr(trig_sel_pkg::OFS_SRC_SEL, {27'h0, t_src[i], 4'h0}, r);
            axi_wr(trig_sel_pkg::OFS_MODE_CFG, {16'h0, t_mode[i]}, r);
            repeat (12) @(posedge clk_sys);
            lvl <= 1'b1;
            watch(t_mask[i], seen);
            `CHK("rise", t_rise[i], seen)
            lvl <= 1'b0;
            watch(t_mask[i], seen);
            `CHK("fall", t_fall[i], seen)
        end
        // The master interrupt counts only under its own trigger code.
        for (int i = 0; i < 2; i++)
        begin
            axi_wr(trig_sel_pkg::OFS_MODE_CFG, i ? 32'h1000 : 32'h1400, r);
            master_irq <= 1'b1;
            @(posedge clk_sys);
            master_irq <= 1'b0;
            watch(3'h7, seen);
            `CHK("master", i ? 3'h0 : 3'h3, seen)
        end
        axi_wr(trig_sel_pkg::OFS_CTRL, 32'h1, r);
        watch(3'h7, seen);
        `CHK("sw start", 3'h2, seen)
        // Sticky flags clear on write; a prohibited trigger code is flagged.
        axi_rd(trig_sel_pkg::OFS_STATUS, d, r);
        `CHK("sticky set", 32'h6, d)
        axi_wr(trig_sel_pkg::OFS_STATUS, 32'h6, r);
        axi_wr(trig_sel_pkg::OFS_MODE_CFG, 32'h0300, r);
        axi_rd(trig_sel_pkg::OFS_STATUS, d, r);
        `CHK("bad trig", 32'h8, d)
        // Clock 0 at half rate, clock 1 at quarter rate.
        axi_wr(trig_sel_pkg::OFS_PRESC, 32'h21, r);
        for (int i = 0; i < 2; i++)
        begin
            axi_wr(trig_sel_pkg::OFS_MODE_CFG, i ? 32'h8000 : 32'h0, r);
            n_op = 5'h0;
            n_cnt = 5'h0;
            repeat (16)
            begin
                @(posedge clk_sys);
                n_op = n_op + trig.op_tick;
                n_cnt = n_cnt + trig.count_tick;
            end
            `CHK("op ticks", i ? 5'h4 : 5'h8, n_op)
            `CHK("count ticks", i ? 5'h4 : 5'h8, n_cnt)
        end
        tally_and_finish();
    end
endmodule : testbench
